// ### pkg/clkbuf_regs_pkg.sv
// register map constants for the pin readback, identity and byte count registers
// assumes byte-wide register access driven by a serial management framing layer
package clkbuf_regs_pkg;

  // register offsets
  localparam logic [7:0] PIN_LEVEL_READBACK_B_OFS  = 8'h04;
  localparam logic [7:0] REVISION_VENDOR_IDENT_OFS = 8'h05;
  localparam logic [7:0] PART_IDENT_OFS            = 8'h06;
  localparam logic [7:0] READBACK_LENGTH_OFS       = 8'h07;

  // field positions in the pin readback register
  localparam int SEL_INPUT_A_POS   = 4;
  localparam int PIN_13_14_POS     = 3;
  localparam int RSVD_ONE_POS      = 2;
  localparam int PIN_12_POS        = 1;
  localparam int PIN_11_POS        = 0;

  // reserved bit values and reset values
  localparam logic [7:0] PIN_READBACK_FIXED = 8'h04;
  localparam logic [7:0] READBACK_LENGTH_RST = 8'h07;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

endpackage : clkbuf_regs_pkg

// ### rtl/clock_buffer_smbus_readback_regs.sv
// pin readback, identity and byte count registers of a clock buffer, plus
// the gating of the group enable pins and a block read byte sequencer
// assumes a framing layer issues byte reads, writes and block read steps
//
// Function
// RULE1: bit 4 of register 4 reads the input select pin, 1 for input A, 0 for input B.
// RULE2: bits 3, 1 and 0 of register 4 read the live levels of the three group enable pins.
// RULE3: a pair is driven only when its enable bit is 1 and its active low pin is 0.
// RULE4: register 5 holds a fixed revision nibble above a fixed maker nibble, writes ignored.
// RULE5: register 6 is a fixed eight bit part code with bit 7 most significant.
// RULE6: register 7 is a writable count, reset 7, that sets the bytes of a block read.
// RULE7: reserved bits read their fixed default or 0 and ignore writes.
`timescale 1ns/1ps
module clock_buffer_smbus_readback_regs
  import clkbuf_regs_pkg::*;
#(
  parameter logic [3:0] REVISION_FIELD = 4'h3, // arbitrary value
  parameter logic [3:0] MAKER_FIELD    = 4'h5, // arbitrary value
  parameter logic [7:0] PART_CODE      = 8'hA6 // arbitrary value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // device pins
  input  wire logic       sel_input_a,
  input  wire logic       enable_pin_outputs_13_14_n,
  input  wire logic       enable_pin_output_12_n,
  input  wire logic       enable_pin_output_11_n,
  // output control bits held in the lower registers
  input  wire logic [1:0] out_ctl_13_14,
  input  wire logic       out_ctl_12,
  input  wire logic       out_ctl_11,
  // drive enables of the differential pairs
  output logic      [1:0] drive_en_13_14,
  output logic            drive_en_12,
  output logic            drive_en_11,
  // single byte access
  input  wire logic [7:0] acc_index,
  input  wire logic       acc_write,
  input  wire logic [7:0] acc_wdata,
  input  wire logic       acc_read,
  output logic      [7:0] acc_rdata_ff,
  output logic            acc_rvalid_ff,
  // block read steps
  input  wire logic       blk_start,
  input  wire logic       blk_next,
  output logic      [7:0] blk_byte_ff,
  output logic            blk_valid_ff,
  output logic            blk_last_ff,
  output logic            blk_busy,
  // current block read length
  output logic      [7:0] readback_length
);

  typedef enum logic [2:0] {
    BLK_IDLE  = 3'b001,
    BLK_COUNT = 3'b010,
    BLK_DATA  = 3'b100
  } blk_state_t;

  logic [7:0] readback_length_ff;
  logic [7:0] nxt_readback_length;
  blk_state_t blk_state_ff;
  blk_state_t nxt_blk_state;
  logic [7:0] blk_index_ff;
  logic [7:0] nxt_blk_index;
  logic [7:0] blk_left_ff;
  logic [7:0] nxt_blk_left;
  logic [7:0] pin_byte;
  logic [7:0] ident_byte;
  logic [7:0] acc_byte;
  logic [7:0] blk_data_byte;
  logic       len_write;
  logic       step_count;
  logic       step_data;

  // live pin image, bit 2 fixed at 1 and the top three bits at 0
  assign pin_byte = PIN_READBACK_FIXED                              // RULE7
                  | (8'(sel_input_a) << SEL_INPUT_A_POS)            // RULE1
                  | (8'(enable_pin_outputs_13_14_n) << PIN_13_14_POS) // RULE2
                  | (8'(enable_pin_output_12_n) << PIN_12_POS)      // RULE2
                  | (8'(enable_pin_output_11_n) << PIN_11_POS);     // RULE2

  // identity is wired constant, so a write can never reach it
  assign ident_byte = {REVISION_FIELD, MAKER_FIELD}; // RULE4

  // read decode shared by single reads and block reads
  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                          input logic [7:0] pins,
                                          input logic [7:0] ident,
                                          input logic [7:0] len);
    logic [7:0] r;
    r = UNMAPPED_READ;
    case (idx)
      PIN_LEVEL_READBACK_B_OFS:  r = pins;
      REVISION_VENDOR_IDENT_OFS: r = ident;
      PART_IDENT_OFS:            r = PART_CODE; // RULE5
      READBACK_LENGTH_OFS:       r = len;
      default:                   r = UNMAPPED_READ;
    endcase
    return r;
  endfunction : read_mux

  assign acc_byte      = read_mux(acc_index, pin_byte, ident_byte, readback_length_ff);
  assign blk_data_byte = read_mux(blk_index_ff, pin_byte, ident_byte, readback_length_ff);

  // only the count register takes writes; others in this range are read only
  assign len_write           = acc_write && (acc_index == READBACK_LENGTH_OFS);
  assign nxt_readback_length = len_write ? acc_wdata : readback_length_ff; // RULE6
  assign readback_length     = readback_length_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readback_length_ff <= READBACK_LENGTH_RST;
    end else begin
      readback_length_ff <= nxt_readback_length;
    end
  end

  // single byte read answers one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_rdata_ff  <= 8'h00;
      acc_rvalid_ff <= 1'b0;
    end else begin
      acc_rdata_ff  <= acc_read ? acc_byte : acc_rdata_ff;
      acc_rvalid_ff <= acc_read;
    end
  end

  // block read: count byte first, then count data bytes from the start index
  assign step_count = (blk_state_ff == BLK_COUNT) && blk_next;
  assign step_data  = (blk_state_ff == BLK_DATA) && blk_next;
  assign blk_busy   = (blk_state_ff != BLK_IDLE);

  always_comb begin
    nxt_blk_state = blk_state_ff;
    nxt_blk_index = blk_index_ff;
    nxt_blk_left  = blk_left_ff;
    case (blk_state_ff)
      BLK_IDLE: begin
        if (blk_start) begin
          nxt_blk_state = BLK_COUNT;
          nxt_blk_index = acc_index;
          nxt_blk_left  = readback_length_ff; // RULE6
        end
      end
      BLK_COUNT: begin
        if (blk_next) begin
          nxt_blk_state = (blk_left_ff == 8'h00) ? BLK_IDLE : BLK_DATA;
        end
      end
      BLK_DATA: begin
        if (blk_next) begin
          nxt_blk_index = blk_index_ff + 8'h01;
          nxt_blk_left  = blk_left_ff - 8'h01;
          if (blk_left_ff == 8'h01) begin
            nxt_blk_state = BLK_IDLE;
          end
        end
      end
      default: begin
        nxt_blk_state = BLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_state_ff <= BLK_IDLE;
      blk_index_ff <= 8'h00;
      blk_left_ff  <= 8'h00;
    end else begin
      blk_state_ff <= nxt_blk_state;
      blk_index_ff <= nxt_blk_index;
      blk_left_ff  <= nxt_blk_left;
    end
  end

  // block output byte; the last flag lets the framing layer send its not-ack window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_byte_ff  <= 8'h00;
      blk_valid_ff <= 1'b0;
      blk_last_ff  <= 1'b0;
    end else begin
      blk_valid_ff <= step_count || step_data;
      blk_last_ff  <= (step_count && blk_left_ff == 8'h00)
                   || (step_data && blk_left_ff == 8'h01);
      if (step_count) begin
        blk_byte_ff <= blk_left_ff;
      end else if (step_data) begin
        blk_byte_ff <= blk_data_byte;
      end
    end
  end

  // one gate per pin group; the 13/14 pin steers two pairs
  out_enable_gate #(.WIDTH(2)) u_gate_13_14 (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .reg_enable      (out_ctl_13_14),
    .pin_enable_n    (enable_pin_outputs_13_14_n),
    .drive_enable_ff (drive_en_13_14)
  );
  out_enable_gate #(.WIDTH(1)) u_gate_12 (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .reg_enable      (out_ctl_12),
    .pin_enable_n    (enable_pin_output_12_n),
    .drive_enable_ff (drive_en_12)
  );
  out_enable_gate #(.WIDTH(1)) u_gate_11 (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .reg_enable      (out_ctl_11),
    .pin_enable_n    (enable_pin_output_11_n),
    .drive_enable_ff (drive_en_11)
  );

  // checks
  AST_SEL_READBACK: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    acc_read && acc_index == PIN_LEVEL_READBACK_B_OFS
      |=> acc_rdata_ff[SEL_INPUT_A_POS] == $past(sel_input_a))
    else $error("input select readback wrong");

  AST_PIN_READBACK: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    acc_read && acc_index == PIN_LEVEL_READBACK_B_OFS
      |=> acc_rdata_ff[PIN_13_14_POS] == $past(enable_pin_outputs_13_14_n)
       && acc_rdata_ff[PIN_12_POS] == $past(enable_pin_output_12_n)
       && acc_rdata_ff[PIN_11_POS] == $past(enable_pin_output_11_n))
    else $error("enable pin readback wrong");

  AST_GROUP_GATE: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    enable_pin_output_12_n |=> !drive_en_12)
    else $error("pair 12 driven while its pin is high");

  AST_IDENT_FIXED: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    acc_read && acc_index == REVISION_VENDOR_IDENT_OFS
      |=> acc_rdata_ff == {REVISION_FIELD, MAKER_FIELD})
    else $error("revision and maker byte wrong");

  AST_PART_FIXED: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    acc_read && acc_index == PART_IDENT_OFS |=> acc_rdata_ff == PART_CODE)
    else $error("part code wrong");

  sequence blk_begin_s;
    blk_start && blk_state_ff == BLK_IDLE;
  endsequence
  sequence blk_count_out_s;
    blk_next ##1 blk_valid_ff;
  endsequence

  AST_BLOCK_COUNT: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    blk_begin_s ##1 blk_count_out_s |-> blk_byte_ff == $past(readback_length_ff, 2))
    else $error("block read count byte differs from length");

  AST_BUSY_AFTER_START: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    blk_begin_s |=> blk_busy)
    else $error("block read not busy after start");

  AST_LEN_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    acc_write && acc_index == READBACK_LENGTH_OFS |=> readback_length_ff == $past(acc_wdata))
    else $error("length register did not take write");

  AST_RESERVED_BITS: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    acc_read && acc_index == PIN_LEVEL_READBACK_B_OFS
      |=> acc_rdata_ff[7:5] == 3'b000 && acc_rdata_ff[RSVD_ONE_POS])
    else $error("reserved bits of pin readback wrong");

endmodule : clock_buffer_smbus_readback_regs

// ### rtl/out_enable_gate.sv
// registered combine of output enable bits with an active low enable pin
// assumes pin level is synchronous to clk
`timescale 1ns/1ps
module out_enable_gate #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // enable sources
  input  wire logic [WIDTH-1:0] reg_enable,
  input  wire logic             pin_enable_n,
  // drive enable of the differential pairs
  output logic      [WIDTH-1:0] drive_enable_ff
);

  logic [WIDTH-1:0] nxt_drive_enable;

  // both the bit and the pin must agree, else the pair floats
  assign nxt_drive_enable = reg_enable & {WIDTH{~pin_enable_n}}; // RULE3

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_enable_ff <= '0;
    end else begin
      drive_enable_ff <= nxt_drive_enable;
    end
  end

  // the edge that sees reset still high is skipped: the flop kept its reset value there
  AST_GATE_BOTH: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    !sys_rst |=> drive_enable_ff == ($past(reg_enable) & {WIDTH{~$past(pin_enable_n)}}))
    else $error("output enable does not follow bit and pin");

endmodule : out_enable_gate

// ### verification/clock_buffer_smbus_readback_regs_test.sv
// self checking bench for the readback, identity and count registers
// assumes the host model drives requests; results are matched from a queue
`timescale 1ns/1ps
module clock_buffer_smbus_readback_regs_test;
  import clkbuf_regs_pkg::*;
  localparam logic [3:0] REV_ID   = 4'h9; // arbitrary value
  localparam logic [3:0] MAKER_ID = 4'hC; // arbitrary value
  localparam logic [7:0] PART_ID  = 8'h3B; // arbitrary value
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       sel_input_a = 1'b0;
  logic [2:0] pins_n = 3'h7;
  logic [3:0] ctl = 4'h0;
  logic [7:0] r = 8'h00;
  wire  [7:0] acc_index, acc_wdata, acc_rdata_ff, blk_byte_ff, readback_length;
  wire        acc_write, acc_read, blk_start, blk_next, acc_rvalid_ff;
  wire        blk_valid_ff, blk_last_ff, blk_busy, drive_en_12, drive_en_11;
  wire  [1:0] drive_en_13_14;
  logic [8:0] expect_q[$];
  int         n_errors = 0;
  int         n_compared = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  smbus_host_model host (.clk(clk), .acc_index(acc_index), .acc_write(acc_write),
    .acc_wdata(acc_wdata), .acc_read(acc_read), .blk_start(blk_start), .blk_next(blk_next));

  clock_buffer_smbus_readback_regs #(.REVISION_FIELD(REV_ID), .MAKER_FIELD(MAKER_ID),
    .PART_CODE(PART_ID)) dut (.clk(clk), .sys_rst(sys_rst), .sel_input_a(sel_input_a),
    .enable_pin_outputs_13_14_n(pins_n[2]), .enable_pin_output_12_n(pins_n[1]),
    .enable_pin_output_11_n(pins_n[0]), .out_ctl_13_14(ctl[3:2]), .out_ctl_12(ctl[1]),
    .out_ctl_11(ctl[0]), .drive_en_13_14(drive_en_13_14), .drive_en_12(drive_en_12),
    .drive_en_11(drive_en_11), .acc_index(acc_index), .acc_write(acc_write),
    .acc_wdata(acc_wdata), .acc_read(acc_read), .acc_rdata_ff(acc_rdata_ff),
    .acc_rvalid_ff(acc_rvalid_ff), .blk_start(blk_start), .blk_next(blk_next),
    .blk_byte_ff(blk_byte_ff), .blk_valid_ff(blk_valid_ff), .blk_last_ff(blk_last_ff),
    .blk_busy(blk_busy), .readback_length(readback_length));

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // note the answer first, then let the host ask
  task automatic rd_exp(input logic [7:0] idx, input logic [7:0] exp);
    expect_q.push_back({1'b0, exp});
    host.rd(idx);
  endtask : rd_exp

  // every result pulse takes the oldest note; an empty queue reads as a bad value
  always @(negedge clk) begin
    if (acc_rvalid_ff === 1'b1)
      check("acc_rdata", expect_q.size() ? expect_q.pop_front() : 9'h1FF,
            {1'b0, acc_rdata_ff});
    if (blk_valid_ff === 1'b1)
      check("blk_byte", expect_q.size() ? expect_q.pop_front() : 9'h1FF,
            {blk_last_ff, blk_byte_ff});
  end

  // watchdog well beyond the roughly 130 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(17));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("length_reset", 9'h007, {1'b0, readback_length});
    // random pin levels and enable bits; gate is registered, so one edge later
    for (int i = 0; i < 16; i++) begin
      r = 8'($urandom());
      @(posedge clk);
      {sel_input_a, pins_n} <= r[3:0];
      ctl <= r[7:4];
      @(posedge clk);
      @(negedge clk);
      check("drive_en", {5'h00, r[7:6] & {2{~r[2]}}, r[5] & ~r[1], r[4] & ~r[0]},
            {5'h00, drive_en_13_14, drive_en_12, drive_en_11});
      rd_exp(PIN_LEVEL_READBACK_B_OFS, {3'h0, r[3:2], 1'b1, r[1:0]});
    end
    // read-only places keep their value after writes
    host.wr(PIN_LEVEL_READBACK_B_OFS, 8'hFF);
    host.wr(REVISION_VENDOR_IDENT_OFS, 8'h00);
    host.wr(PART_IDENT_OFS, 8'h00);
    rd_exp(PIN_LEVEL_READBACK_B_OFS, {3'h0, r[3:2], 1'b1, r[1:0]});
    rd_exp(REVISION_VENDOR_IDENT_OFS, {REV_ID, MAKER_ID});
    rd_exp(PART_IDENT_OFS, PART_ID);
    rd_exp(8'h03, UNMAPPED_READ);
    rd_exp(8'hFF, UNMAPPED_READ);
    // count written, then block reads of that length, including zero and past the map
    host.wr(READBACK_LENGTH_OFS, 8'h02);
    @(negedge clk);
    check("length_write", 9'h002, {1'b0, readback_length});
    rd_exp(READBACK_LENGTH_OFS, 8'h02);
    expect_q.push_back(9'h002);
    expect_q.push_back({1'b0, REV_ID, MAKER_ID});
    expect_q.push_back({1'b1, PART_ID});
    host.blk(REVISION_VENDOR_IDENT_OFS, 8'h02);
    host.wr(READBACK_LENGTH_OFS, 8'h00);
    expect_q.push_back(9'h100);
    host.blk(PIN_LEVEL_READBACK_B_OFS, 8'h00);
    host.wr(READBACK_LENGTH_OFS, 8'h03);
    expect_q.push_back(9'h003);
    expect_q.push_back({1'b0, PART_ID});
    expect_q.push_back(9'h003);
    expect_q.push_back(9'h100);
    host.blk(PART_IDENT_OFS, 8'h03);
    @(negedge clk);
    check("blk_busy", 9'h000, {8'h00, blk_busy});
    // reset in mid-run brings the count back to its default and drops the gates
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("length_rerst", 9'h007, {1'b0, readback_length});
    check("drive_en_rst", 9'h000, {5'h00, drive_en_13_14, drive_en_12, drive_en_11});
    rd_exp(READBACK_LENGTH_OFS, 8'h07);
    repeat (5) @(posedge clk);
    check("pending_results", 9'h000, 9'(expect_q.size()));
    summarize();
  end
endmodule : clock_buffer_smbus_readback_regs_test

// ### verification/smbus_host_model.sv
// host side model: single byte reads and writes, and block reads
// assumes the block samples every request on the rising edge of clk
`timescale 1ns/1ps
module smbus_host_model (
  // clock
  input  wire logic       clk,
  // requests toward the block
  output logic      [7:0] acc_index,
  output logic            acc_write,
  output logic      [7:0] acc_wdata,
  output logic            acc_read,
  output logic            blk_start,
  output logic            blk_next
);
  // quiet lines at time zero
  initial begin
    {acc_index, acc_wdata} = 16'h0000;
    {acc_write, acc_read, blk_start, blk_next} = 4'h0;
  end

  // released lines flip so a stale index never looks like a live one
  task automatic release_lines();
    acc_index <= ~acc_index;
    acc_wdata <= ~acc_wdata;
  endtask : release_lines

  // one write strobe; the count register is changed this way
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk);
    acc_index <= idx;
    acc_wdata <= data;
    acc_write <= 1'b1;
    @(posedge clk);
    acc_write <= 1'b0;
    release_lines();
  endtask : wr

  // one read strobe; the answer shows after the next edge
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    acc_index <= idx;
    acc_read  <= 1'b1;
    @(posedge clk);
    acc_read  <= 1'b0;
    release_lines();
  endtask : rd

  // block read: count byte first, then cnt data bytes, steps back to back
  task automatic blk(input logic [7:0] idx, input logic [7:0] cnt);
    @(posedge clk);
    acc_index <= idx;
    blk_start <= 1'b1;
    @(posedge clk);
    blk_start <= 1'b0;
    release_lines();
    blk_next  <= 1'b1;
    repeat (int'(cnt) + 1) @(posedge clk);
    blk_next  <= 1'b0;
  endtask : blk
endmodule : smbus_host_model
